//--- design/dtc_pkg.sv
// Constants shared by the dual 8-bit timer/event counter
package dtc_pkg;

  // Register byte addresses, index 0 is counter A, index 1 counter B
  localparam logic [15:0] DTC_MODE_ADDR [0:1] = '{16'hff70, 16'hff74};
  localparam logic [15:0] DTC_CSEL_ADDR [0:1] = '{16'hff71, 16'hff75};
  localparam logic [15:0] DTC_CMP_ADDR  [0:1] = '{16'hff72, 16'hff76};
  localparam logic [15:0] DTC_CNT_ADDR  [0:1] = '{16'hff73, 16'hff77};

  // Mode control field positions
  localparam int DTC_RUN_BIT  = 7;
  localparam int DTC_PWM_BIT  = 6;
  localparam int DTC_CASC_BIT = 4;
  localparam int DTC_SET_BIT  = 3;
  localparam int DTC_CLR_BIT  = 2;
  localparam int DTC_INV_BIT  = 1;
  localparam int DTC_OE_BIT   = 0;

  // Bits kept by a write; set/reset strobes are never stored
  localparam logic [7:0] DTC_MODE_KEEP [0:1] = '{8'hc3, 8'hd3};
  localparam logic [7:0] DTC_CSEL_KEEP = 8'h07;

  // Reset values
  localparam logic [7:0] DTC_RST_BYTE = 8'h00;
  localparam logic [2:0] DTC_RST_CSEL = 3'h0;
  localparam logic [11:0] DTC_RST_DIV = 12'h000;

  // Count clock codes
  localparam logic [2:0] DTC_CODE_FALL = 3'h0;
  localparam logic [2:0] DTC_CODE_RISE = 3'h1;
  localparam logic [2:0] DTC_CODE_DIV8 = 3'h2;

  // Prescaler masks (divisor minus one) for codes 2 to 7
  localparam logic [11:0] DTC_MASK_A [0:5] =
    '{12'h007, 12'h01f, 12'h07f, 12'h0ff, 12'h1ff, 12'h7ff};
  localparam logic [11:0] DTC_MASK_B [0:5] =
    '{12'h00f, 12'h03f, 12'h07f, 12'h0ff, 12'h3ff, 12'hfff};

  // Main clock period in ns
  localparam int DTC_CLK_PERIOD_NS = 10;

endpackage

//--- design/dtc_clk_sel.sv
// Count clock selector: pin edge or prescaler tap
`timescale 1ns/1ps
`default_nettype none
module dtc_clk_sel (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic [2:0]  code_in,
  input  wire logic        table_b_in,
  input  wire logic [11:0] div_in,
  input  wire logic        ext_pin_in,
  output logic             tick_out
);

  logic        pin_prev_r;
  logic [11:0] mask;
  logic [2:0]  idx;

  // Previous pin level for edge detection
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      pin_prev_r <= 1'b0;
    else
      pin_prev_r <= ext_pin_in;
  end

  // Tap mask for the prescaler codes
  always_comb
  begin
    idx  = code_in - dtc_pkg::DTC_CODE_DIV8;
    mask = table_b_in ? dtc_pkg::DTC_MASK_B[idx]
                      : dtc_pkg::DTC_MASK_A[idx];
  end

  // One-cycle count tick
  always_comb
  begin
    if (code_in == dtc_pkg::DTC_CODE_FALL)
      tick_out = pin_prev_r & ~ext_pin_in;
    else if (code_in == dtc_pkg::DTC_CODE_RISE)
      tick_out = ~pin_prev_r & ext_pin_in;
    else
      tick_out = &(div_in | ~mask);
  end

endmodule
`default_nettype wire

//--- design/dtc_timer.sv
// Dual 8-bit timer/event counter with 16-bit cascade
//
// What this block does
// - Each counter makes an 8-bit resolution PWM output.
// - Cascade gives 16-bit interval, event count and square wave, no PWM.
// - Counts external input pin pulses for software to read.
// - Square wave output set by count clock and compare value.
// - Count equal to compare raises that counter's match interrupt.
// - Compare registers take any value from zero to maximum.
// - Reset clears both compare registers.
// - Count registers read as bytes and clear on reset.
// - Clearing run enable A in cascade zeroes the 16-bit count.
// - Clock code picks pin falling, rising edge or divided clock.
// - Timer output is unusable while counting from the pin.
// - Reset clears clock select, choosing the pin falling edge.
// - Run enable 0 stops and clears the count; 1 counts.
// - PWM select 0 clears on match, 1 runs freely.
// - Cascade select joins the two counters into 16 bits.
// - Invert selects PWM active level, else enables toggle on match.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic      [7:0]  rd_data_out,
  input  wire logic        ext_count_input_a_in,
  input  wire logic        ext_count_input_b_in,
  output logic             timer_out_a_out,
  output logic             timer_out_b_out,
  output logic             match_irq_a_out,
  output logic             match_irq_b_out
);

  logic [7:0]  mode_r    [0:1];
  logic [2:0]  clk_sel_r [0:1];
  logic [7:0]  cmp_r     [0:1];
  logic [7:0]  cnt_r     [0:1];
  logic [7:0]  cnt_nxt   [0:1];
  logic [15:0] cnt16_nxt;
  logic [11:0] div_r;
  logic [1:0]  tick;
  logic [1:0]  run;
  logic [1:0]  pwm;
  logic [1:0]  inv;
  logic [1:0]  oe;
  logic [1:0]  match;
  logic [1:0]  adv;
  logic [1:0]  hit;
  logic [1:0]  ext_sel;
  logic [1:0]  wr_mode;
  logic [1:0]  pwm_act;
  logic [1:0]  tff_r;
  logic [1:0]  tout_r;
  logic [1:0]  irq_r;
  logic [7:0]  rd_data_r;
  logic [7:0]  rd_nxt;
  logic        cascade;
  logic        match16;
  logic [1:0]  ext_pin;

  assign ext_pin = {ext_count_input_b_in, ext_count_input_a_in};
  assign cascade = mode_r[1][dtc_pkg::DTC_CASC_BIT];
  assign match16 = match[0] & match[1];

  // Free-running prescaler shared by both counters
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      div_r <= dtc_pkg::DTC_RST_DIV;
    else
      div_r <= div_r + 12'h001;
  end

  // Per-counter decode, clock source and mode bits
  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    dtc_clk_sel u_sel (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .code_in    (clk_sel_r[i]),
      .table_b_in (i == 1),
      .div_in     (div_r),
      .ext_pin_in (ext_pin[i]),
      .tick_out   (tick[i])
    );
    assign wr_mode[i] = wr_en_in &&
                        addr_in == dtc_pkg::DTC_MODE_ADDR[i];
    // Cascade runs both halves from counter A's run enable and clock select
    assign run[i] = cascade ? mode_r[0][dtc_pkg::DTC_RUN_BIT]
                            : mode_r[i][dtc_pkg::DTC_RUN_BIT];
    assign pwm[i] = mode_r[i][dtc_pkg::DTC_PWM_BIT] & ~cascade;
    assign inv[i] = mode_r[i][dtc_pkg::DTC_INV_BIT];
    assign oe[i]  = mode_r[i][dtc_pkg::DTC_OE_BIT];
    assign match[i] = cnt_r[i] == cmp_r[i];
    assign ext_sel[i] = cascade ? clk_sel_r[0][2:1] == 2'b00
                                : clk_sel_r[i][2:1] == 2'b00;
    assign pwm_act[i] = run[i] && cnt_r[i] < cmp_r[i];
  end

  // Software-written configuration
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < 2; i++)
      begin
        mode_r[i]    <= dtc_pkg::DTC_RST_BYTE;
        clk_sel_r[i] <= dtc_pkg::DTC_RST_CSEL;
        cmp_r[i]     <= dtc_pkg::DTC_RST_BYTE;
      end
    end
    else if (wr_en_in)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (addr_in == dtc_pkg::DTC_MODE_ADDR[i])
          mode_r[i] <= wr_data_in & dtc_pkg::DTC_MODE_KEEP[i];
        else if (addr_in == dtc_pkg::DTC_CSEL_ADDR[i])
          clk_sel_r[i] <= 3'(wr_data_in & dtc_pkg::DTC_CSEL_KEEP);
        else if (addr_in == dtc_pkg::DTC_CMP_ADDR[i])
          cmp_r[i] <= wr_data_in;
      end
    end
  end

  // Next count for individual and cascade operation
  always_comb
  begin
    cnt16_nxt = {cnt_r[1], cnt_r[0]} + 16'h0001;
    cnt_nxt[0] = cnt_r[0];
    cnt_nxt[1] = cnt_r[1];
    adv = 2'b00;
    if (cascade)
    begin
      if (!run[0])
      begin
        cnt_nxt[0] = 8'h00;
        cnt_nxt[1] = 8'h00;
      end
      else if (tick[0])
      begin
        adv = 2'b11;
        if (match16)
        begin
          cnt_nxt[0] = 8'h00;
          cnt_nxt[1] = 8'h00;
        end
        else
        begin
          cnt_nxt[0] = cnt16_nxt[7:0];
          cnt_nxt[1] = cnt16_nxt[15:8];
        end
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!run[i])
          cnt_nxt[i] = 8'h00;
        else if (tick[i])
        begin
          adv[i] = 1'b1;
          if (!pwm[i] && match[i])
            cnt_nxt[i] = 8'h00;
          else
            cnt_nxt[i] = cnt_r[i] + 8'h01;
        end
      end
    end
  end

  // Match events: counted value lands on the compare value
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (cascade)
        hit[i] = adv[i] && cnt_nxt[0] == cmp_r[0] &&
                 cnt_nxt[1] == cmp_r[1];
      else
        hit[i] = adv[i] && cnt_nxt[i] == cmp_r[i];
    end
  end

  // Count registers
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      cnt_r[0] <= dtc_pkg::DTC_RST_BYTE;
      cnt_r[1] <= dtc_pkg::DTC_RST_BYTE;
    end
    else
    begin
      cnt_r[0] <= cnt_nxt[0];
      cnt_r[1] <= cnt_nxt[1];
    end
  end

  // Match interrupt pulses
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      irq_r <= 2'b00;
    else
      irq_r <= hit;
  end

  // Output flip-flops: direct set/reset, else toggle on match
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      tff_r <= 2'b00;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_mode[i] && wr_data_in[dtc_pkg::DTC_SET_BIT] &&
            !wr_data_in[dtc_pkg::DTC_CLR_BIT])
          tff_r[i] <= 1'b1;
        else if (wr_mode[i] && wr_data_in[dtc_pkg::DTC_CLR_BIT] &&
                 !wr_data_in[dtc_pkg::DTC_SET_BIT])
          tff_r[i] <= 1'b0;
        else if (hit[i] && inv[i] && !pwm[i])
          tff_r[i] <= ~tff_r[i];
      end
    end
  end

  // Timer pins: PWM level or square wave, off when pin-clocked
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      tout_r <= 2'b00;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!oe[i] || ext_sel[i])
          tout_r[i] <= 1'b0;
        else if (pwm[i])
          tout_r[i] <= pwm_act[i] ^ inv[i];
        else
          tout_r[i] <= tff_r[i];
      end
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb
  begin
    rd_nxt = 8'h00;
    for (int i = 0; i < 2; i++)
    begin
      if (addr_in == dtc_pkg::DTC_MODE_ADDR[i])
        rd_nxt = mode_r[i];
      else if (addr_in == dtc_pkg::DTC_CSEL_ADDR[i])
        rd_nxt = {5'h00, clk_sel_r[i]};
      else if (addr_in == dtc_pkg::DTC_CMP_ADDR[i])
        rd_nxt = cmp_r[i];
      else if (addr_in == dtc_pkg::DTC_CNT_ADDR[i])
        rd_nxt = cnt_r[i];
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      rd_data_r <= dtc_pkg::DTC_RST_BYTE;
    else if (rd_en_in)
      rd_data_r <= rd_nxt;
    else
      rd_data_r <= dtc_pkg::DTC_RST_BYTE;
  end

  assign rd_data_out     = rd_data_r;
  assign timer_out_a_out = tout_r[0];
  assign timer_out_b_out = tout_r[1];
  assign match_irq_a_out = irq_r[0];
  assign match_irq_b_out = irq_r[1];

  // Checks on the counting behaviour
  reset_clears_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in) $rose(rst_b_in) |-> cmp_r[0] == 8'h00 &&
    cmp_r[1] == 8'h00 && cnt_r[0] == 8'h00 && clk_sel_r[0] == 3'h0)
    else $error("registers not cleared by reset");

  stop_clear_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in)
    !cascade && !mode_r[0][dtc_pkg::DTC_RUN_BIT] |=> cnt_r[0] == 8'h00)
    else $error("stopped counter A not cleared");

  casc_clear_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in) cascade && !run[0] && $stable(cascade)
    |=> cnt_r[0] == 8'h00 && cnt_r[1] == 8'h00)
    else $error("cascade count not cleared on stop");

  irq_value_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in) match_irq_a_out && !$past(cascade)
    |-> cnt_r[0] == $past(cmp_r[0]))
    else $error("match interrupt without equal count");

  restart_zero_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in)
    !cascade && run[0] && !pwm[0] && tick[0] && match[0]
    |=> cnt_r[0] == 8'h00)
    else $error("counter did not restart after match");

  pwm_free_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in) !cascade && run[0] && pwm[0] && tick[0]
    |=> cnt_r[0] == $past(cnt_r[0]) + 8'h01)
    else $error("PWM counter did not run freely");

  ext_quiet_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in)
    clk_sel_r[0][2:1] == 2'b00 && !cascade |=> !timer_out_a_out)
    else $error("timer output driven while pin clocked");

  casc_carry_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in) cascade && run[0] && tick[0] &&
    !match16 && cnt_r[0] == 8'hff
    |=> cnt_r[1] == $past(cnt_r[1]) + 8'h01 && cnt_r[0] == 8'h00)
    else $error("high byte did not advance on wrap");

  div8_pace_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in)
    clk_sel_r[0] == dtc_pkg::DTC_CODE_DIV8 && tick[0] && !wr_en_in
    |=> (!tick[0] [*7] ##1 tick[0]) or
        (##[0:7] clk_sel_r[0] != dtc_pkg::DTC_CODE_DIV8))
    else $error("divide-by-8 tick spacing wrong");

  // Main scenarios
  cov_irq_a: cover property (@(posedge clk_sys_in)
    disable iff (!rst_b_in) match_irq_a_out && !cascade);
  cov_casc: cover property (@(posedge clk_sys_in)
    disable iff (!rst_b_in) match_irq_b_out && cascade);
  cov_pwm: cover property (@(posedge clk_sys_in)
    disable iff (!rst_b_in) pwm[0] && $rose(timer_out_a_out));
  cov_ext: cover property (@(posedge clk_sys_in)
    disable iff (!rst_b_in) ext_sel[1] && adv[1] && !cascade);

endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the dual 8-bit timer/event counter
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk;
  logic        rst_b;
  logic [15:0] addr;
  logic [7:0]  wdat;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rdat;
  logic        pin_a;
  logic        pin_b;
  logic        out_a;
  logic        out_b;
  logic        irq_a;
  logic        irq_b;
  int          errors;
  int          n_tests;
  int          cyc;
  int          n;
  logic [7:0]  d;
  logic        t1;

  // Design under test
  dtc_timer dut_u (
    .clk_sys_in           (clk),
    .rst_b_in             (rst_b),
    .addr_in              (addr),
    .wr_data_in           (wdat),
    .wr_en_in             (wr_en),
    .rd_en_in             (rd_en),
    .rd_data_out          (rdat),
    .ext_count_input_a_in (pin_a),
    .ext_count_input_b_in (pin_b),
    .timer_out_a_out      (out_a),
    .timer_out_b_out      (out_b),
    .match_irq_a_out      (irq_a),
    .match_irq_b_out      (irq_b)
  );

  // System clock, 10 ns period
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      errors++;
      print_verdict();
    end
  end

  // Counts a comparison and reports a mismatch
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      errors++;
  endtask

  // One-cycle register write
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdat <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rdat;
  endtask

  // Waits for a match pulse, returns cycles spent
  task automatic wait_irq(input logic sel_b, output int k);
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end while (((sel_b ? irq_b : irq_a) !== 1'b1) && k < 5000);
  endtask

  // Drives whole pulses on both count pins
  task automatic pulses(input int cnt);
    repeat (cnt)
    begin
      @(posedge clk);
      pin_a <= 1'b1;
      pin_b <= 1'b1;
      repeat (2) @(posedge clk);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  // Counts cycles with timer output A high over one PWM period
  task automatic high_cycles(output int k);
    k = 0;
    repeat (16) @(posedge clk);
    repeat (2048)
    begin
      @(posedge clk);
      #1;
      if (out_a === 1'b1)
        k++;
    end
  endtask

  // Reset values of every register and an unmapped read
  task automatic test_reset;
    for (int i = 0; i < 2; i++)
    begin
      rd(dtc_pkg::DTC_MODE_ADDR[i], d);
      chk(d, 16'h0000);
      rd(dtc_pkg::DTC_CSEL_ADDR[i], d);
      chk(d, 16'h0000);
      rd(dtc_pkg::DTC_CMP_ADDR[i], d);
      chk(d, 16'h0000);
      rd(dtc_pkg::DTC_CNT_ADDR[i], d);
      chk(d, 16'h0000);
    end
    rd(16'hff78, d);
    chk(d, 16'h0000);
    $display("test reset done");
  endtask

  // Full compare range, clock select width, read-only count
  task automatic test_regs;
    wr(dtc_pkg::DTC_CMP_ADDR[0], 8'hff);
    rd(dtc_pkg::DTC_CMP_ADDR[0], d);
    chk(d, 16'h00ff);
    wr(dtc_pkg::DTC_CMP_ADDR[1], 8'h5a);
    rd(dtc_pkg::DTC_CMP_ADDR[1], d);
    chk(d, 16'h005a);
    wr(dtc_pkg::DTC_CSEL_ADDR[0], 8'h07);
    rd(dtc_pkg::DTC_CSEL_ADDR[0], d);
    chk(d, 16'h0007);
    wr(dtc_pkg::DTC_CNT_ADDR[0], 8'h55);
    rd(dtc_pkg::DTC_CNT_ADDR[0], d);
    chk(d, 16'h0000);
    $display("test regs done");
  endtask

  // Every divided clock code: interval, pulse width, square wave
  task automatic test_interval;
    int divs [0:5] = '{8, 32, 128, 256, 512, 2048};
    wr(dtc_pkg::DTC_CMP_ADDR[0], 8'h01);
    for (int c = 0; c < 6; c++)
    begin
      wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h00);
      wr(dtc_pkg::DTC_CSEL_ADDR[0], 8'(c + 2));
      wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h83);
      wait_irq(1'b0, n);
      wait_irq(1'b0, n);
      chk(n[15:0], 16'(2 * divs[c]));
      @(posedge clk);
      #1;
      chk(irq_a, 1'b0);
      @(posedge clk);
      #1;
      t1 = out_a;
      wait_irq(1'b0, n);
      repeat (2) @(posedge clk);
      #1;
      chk(out_a, !t1);
    end
    // Direct reset then set of the output flop, output enabled
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h05);
    @(posedge clk);
    #1;
    chk(out_a, 1'b0);
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h09);
    @(posedge clk);
    #1;
    chk(out_a, 1'b1);
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h00);
    rd(dtc_pkg::DTC_CNT_ADDR[0], d);
    chk(d, 16'h0000);
    $display("test interval done");
  endtask

  // Pin edges counted, timer output held off while pin-clocked
  task automatic test_events;
    wr(dtc_pkg::DTC_CMP_ADDR[0], 8'hff);
    wr(dtc_pkg::DTC_CMP_ADDR[1], 8'hff);
    wr(dtc_pkg::DTC_CSEL_ADDR[0], 8'h01);
    // Flop set high, so a live output would show on the pin
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h8b);
    wr(dtc_pkg::DTC_MODE_ADDR[1], 8'h80);
    pulses(5);
    rd(dtc_pkg::DTC_CNT_ADDR[0], d);
    chk(d, 16'h0005);
    rd(dtc_pkg::DTC_CNT_ADDR[1], d);
    chk(d, 16'h0005);
    chk(out_a, 1'b0);
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h00);
    wr(dtc_pkg::DTC_CSEL_ADDR[0], 8'h00);
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h80);
    pulses(3);
    rd(dtc_pkg::DTC_CNT_ADDR[0], d);
    chk(d, 16'h0003);
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h00);
    wr(dtc_pkg::DTC_MODE_ADDR[1], 8'h00);
    rd(dtc_pkg::DTC_CNT_ADDR[1], d);
    chk(d, 16'h0000);
    $display("test events done");
  endtask

  // PWM duty at both active levels
  task automatic test_pwm;
    wr(dtc_pkg::DTC_CMP_ADDR[0], 8'h40);
    wr(dtc_pkg::DTC_CSEL_ADDR[0], 8'h02);
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'hc1);
    high_cycles(n);
    chk(n[15:0], 16'd512);
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h00);
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'hc3);
    high_cycles(n);
    chk(n[15:0], 16'd1536);
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h00);
    $display("test pwm done");
  endtask

  // 16-bit cascade: period, joint match, clear on stop
  task automatic test_cascade;
    wr(dtc_pkg::DTC_CMP_ADDR[0], 8'h01);
    wr(dtc_pkg::DTC_CMP_ADDR[1], 8'h01);
    // Cascade with toggle and output enable on the high half
    wr(dtc_pkg::DTC_MODE_ADDR[1], 8'h13);
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h80);
    wait_irq(1'b1, n);
    chk(irq_a, 1'b1);
    t1 = out_b;
    wait_irq(1'b1, n);
    chk(n[15:0], 16'd2064);
    chk(out_b, !t1);
    rd(dtc_pkg::DTC_CNT_ADDR[1], d);
    chk(d, 16'h0001);
    rd(dtc_pkg::DTC_CNT_ADDR[0], d);
    chk(d, 16'h0001);
    wr(dtc_pkg::DTC_MODE_ADDR[0], 8'h00);
    rd(dtc_pkg::DTC_CNT_ADDR[1], d);
    chk(d, 16'h0000);
    rd(dtc_pkg::DTC_CNT_ADDR[0], d);
    chk(d, 16'h0000);
    wr(dtc_pkg::DTC_MODE_ADDR[1], 8'h00);
    $display("test cascade done");
  endtask

  // Closing report and end of run
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    errors = 0;
    n_tests = 0;
    cyc = 0;
    rst_b = 1'b0;
    addr = 16'h0000;
    wdat = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    test_reset();
    test_regs();
    test_interval();
    test_events();
    test_pwm();
    test_cascade();
    print_verdict();
  end
endmodule
`default_nettype wire
